/* core/usb_status_defs.vh */
// Constants for the USB status, flag and endpoint buffer block
`ifndef USB_STATUS_DEFS_VH
`define USB_STATUS_DEFS_VH

// Special function register addresses
`define OFS_SUSPEND_IRQ_EN 8'hE8
`define OFS_DEVICE_ADDRESS 8'hE9
`define OFS_EVENT_FLAGS 8'hEA
`define OFS_CTRL_RX_STATUS 8'hEB
`define OFS_HS_EP_STATUS 8'hEC
`define OFS_BUF_POINTER 8'hED
`define OFS_CTRL_EP_PORT 8'hEE
`define OFS_INTR_EP_PORT 8'hEF
`define OFS_BULK_EP_PORT 8'hF1
`define OFS_IRQ_EN_MAIN 8'hA8
`define OFS_IRQ_EN_EXTRA 8'hB8

// Bit positions in the suspend/enable, event flag and interrupt enable registers
`define BIT_SUSPEND 7
`define BIT_RESUME 7
`define BIT_ALL_IRQ_EN 7
`define BIT_USB_GROUP_EN 4

// Reset values
`define RST_BYTE 8'h00

// Token kinds from the packet engine
`define TOK_OUT 2'h0
`define TOK_IN 2'h1
`define TOK_SETUP 2'h2

// Reply codes towards the packet engine
`define REPLY_DATA 2'h0
`define REPLY_ACK 2'h1
`define REPLY_NAK 2'h2
`define REPLY_STALL 2'h3

// Line states as {D+, D-}
`define LINE_SE0 2'h0
`define LINE_J 2'h2

// Timing
`define CLK_PERIOD_PS 5000
`define BUS_RESET_NS 2500
`define EOP_MIN_NS 80
`define IDLE_MIN_NS 1000
`define BUS_RESET_CYC ((`BUS_RESET_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define EOP_MIN_CYC ((`EOP_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define IDLE_MIN_CYC ((`IDLE_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

/* core/usb_status_buffer.v */
// USB suspend, event flags, receive status and endpoint buffer access
`timescale 1ns/1ps
`include "usb_status_defs.vh"

// Overview of operation
// R1: Software clears resume before suspend, ends suspend
// R2: Seven enables gate matching event flags
// R3: Seven-bit address selects our transactions
// R4: Bus activity in suspend sets resume
// R5: Flags clear only on written one
// R6: Long SE0 sets bus-reset flag
// R7: Valid end-of-packet sets its flag
// R8: Transmit-done set after host ACK
// R9: Receive-done set after stored good packet, ACKed or STALLed
// R10: Done flag or cleared ready gives NAK
// R11: Software clears ready before clearing done
// R12: SETUP on endpoint 0 always ACKed
// R13: Setup indicator records SETUP versus OUT
// R14: Record transmit-done seen before receive-done
// R15: Idle bit reads one on idle bus
// R16: Last received data PID per endpoint
// R17: Last received byte count per endpoint
// R18: Endpoint 0 last handshake one-hot bits
// R19: Shared pointer increments on port access
// R20: Endpoints 0,2: write transmit, read receive
// R21: Endpoint 1 port reaches transmit buffer
// R22: Global and group enables gate interrupt
// R23: Endpoint 0 IN NAKs unless ready, done clear
// R24: SETUP token clears endpoint 0 stall requests
// R25: Interrupt line ORs enabled flags and resume
module usb_status_buffer #(
    parameter RESET_CYC = `BUS_RESET_CYC,
    parameter EOP_CYC = `EOP_MIN_CYC,
    parameter IDLE_CYC = `IDLE_MIN_CYC
) (
    input wire clock,
    input wire nrst,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    input wire dp_in,
    input wire dm_in,
    input wire stop_mode,
    input wire ctrl_tx_ready,
    input wire ctrl_rx_ready,
    input wire intr_tx_ready,
    input wire bulk_tx_ready,
    input wire bulk_rx_ready,
    input wire ctrl_out_stall_req,
    input wire ctrl_in_stall_req,
    input wire intr_stall_req,
    input wire bulk_stall_req,
    input wire tok_valid,
    input wire [1:0] tok_kind,
    input wire [6:0] tok_addr,
    input wire [1:0] tok_ep,
    input wire rx_byte_valid,
    input wire [7:0] rx_byte,
    input wire rx_end,
    input wire rx_good,
    input wire rx_pid_data1,
    input wire host_ack,
    input wire tx_rd_req,
    input wire [2:0] tx_rd_idx,
    output reg [7:0] tx_rd_data,
    output reg reply_valid,
    output reg [1:0] reply_code,
    output reg stall_clear,
    output reg suspend,
    output reg [6:0] device_address,
    output reg cpu_wake,
    output reg irq
);
    localparam CW = 10;
    // Event flag bit order: resume, reset, eop, bulk tx/rx, intr tx,
    // ctrl rx, ctrl tx
    localparam F_RST = 6;
    localparam F_EOP = 5;
    localparam F_BTX = 4;
    localparam F_BRX = 3;
    localparam F_ITX = 2;
    localparam F_CRX = 1;
    localparam F_CTX = 0;

    reg [7:0] en_q;
    reg [7:0] flags_q;
    reg [7:0] flags_d;
    reg [7:0] ien_main_q;
    reg [7:0] ien_extra_q;
    reg [2:0] ptr_q;
    reg [7:0] tx_buf [0:23];
    reg [7:0] rx_buf [0:15];
    reg setup_q, tx_first_q, ctrl_seq_q, bulk_seq_q;
    reg [3:0] ctrl_cnt_q, bulk_cnt_q, cnt_q;
    reg hs_stall_q, hs_ack_q, hs_nak_q;
    reg dp_s1, dp_s2, dm_s1, dm_s2;
    reg [1:0] line_prev_q;
    reg [CW-1:0] se0_cnt_q, j_cnt_q;
    reg idle_q;
    reg cur_ours_q, accept_q, in_pend_q;
    reg [1:0] cur_kind_q, cur_ep_q;
    reg [7:0] set_v;
    reg tok_ours, tok_accept;

    wire [1:0] line = {dp_s2, dm_s2};
    wire wr_flags = sfr_wr && sfr_addr == `OFS_EVENT_FLAGS;

    function port_hit;
        input [7:0] a;
        begin
            port_hit = a == `OFS_CTRL_EP_PORT || a == `OFS_INTR_EP_PORT ||
                a == `OFS_BULK_EP_PORT;
        end
    endfunction

    // Buffer base per endpoint; unknown endpoints fold onto the last one
    function [4:0] ep_base;
        input [1:0] ep;
        begin
            case (ep)
                2'h0: ep_base = 5'h00;
                2'h1: ep_base = 5'h08;
                default: ep_base = 5'h10;
            endcase
        end
    endfunction

    // Synchronise the data lines before any decoding
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dp_s1 <= 1'b0;
            dp_s2 <= 1'b0;
            dm_s1 <= 1'b0;
            dm_s2 <= 1'b0;
        end else begin
            dp_s1 <= dp_in;
            dp_s2 <= dp_s1;
            dm_s1 <= dm_in;
            dm_s2 <= dm_s1;
        end
    end

    // Acceptance decision at token time
    always @* begin
        tok_ours = tok_valid && tok_addr == device_address; // [R3]
        tok_accept = 1'b0;
        case (tok_ep)
            2'h0: tok_accept = tok_kind == `TOK_SETUP ||
                (ctrl_rx_ready && !flags_q[F_CRX]); // [R12] [R10]
            2'h2: tok_accept = bulk_rx_ready && !flags_q[F_BRX]; // [R10]
            default: tok_accept = 1'b0;
        endcase
    end

    // Hardware flag sets
    always @* begin
        set_v = 8'h00;
        if (suspend && line != `LINE_J)
            set_v[`BIT_RESUME] = 1'b1; // [R4]
        if (line == `LINE_SE0 && se0_cnt_q == RESET_CYC[CW-1:0] - 1'b1)
            set_v[F_RST] = 1'b1; // [R6]
        if (line == `LINE_J && line_prev_q == `LINE_SE0 &&
            se0_cnt_q >= EOP_CYC[CW-1:0] && se0_cnt_q < RESET_CYC[CW-1:0])
            set_v[F_EOP] = 1'b1; // [R7]
        if (host_ack && in_pend_q) begin // [R8]
            case (cur_ep_q)
                2'h0: set_v[F_CTX] = 1'b1;
                2'h1: set_v[F_ITX] = 1'b1;
                default: set_v[F_BTX] = 1'b1;
            endcase
        end
        if (rx_end && rx_good && cur_ours_q && accept_q) begin // [R9]
            if (cur_ep_q == 2'h0)
                set_v[F_CRX] = 1'b1;
            else
                set_v[F_BRX] = 1'b1;
        end
        // A set in the same cycle as a one-write wins over the clear
        flags_d = (flags_q & ~(wr_flags ? sfr_wdata : 8'h00)) | set_v; // [R5]
    end

    // Line monitor
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            line_prev_q <= `LINE_J;
            se0_cnt_q <= {CW{1'b0}};
            j_cnt_q <= {CW{1'b0}};
            idle_q <= 1'b0;
        end else begin
            line_prev_q <= line;
            if (line == `LINE_SE0) begin
                if (se0_cnt_q != {CW{1'b1}})
                    se0_cnt_q <= se0_cnt_q + 1'b1;
            end else if (line_prev_q != `LINE_SE0) begin
                se0_cnt_q <= {CW{1'b0}};
            end else begin
                se0_cnt_q <= se0_cnt_q;
            end
            if (line != `LINE_J)
                j_cnt_q <= {CW{1'b0}};
            else if (j_cnt_q != {CW{1'b1}})
                j_cnt_q <= j_cnt_q + 1'b1;
            // Idle needs the J state to persist, not a single J bit
            idle_q <= line == `LINE_J && j_cnt_q >= IDLE_CYC[CW-1:0]; // [R15]
        end
    end

    // Transaction tracking and handshakes
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cur_ours_q <= 1'b0;
            cur_kind_q <= `TOK_OUT;
            cur_ep_q <= 2'h0;
            accept_q <= 1'b0;
            in_pend_q <= 1'b0;
            cnt_q <= 4'h0;
            reply_valid <= 1'b0;
            reply_code <= `REPLY_NAK;
            stall_clear <= 1'b0;
            setup_q <= 1'b0;
            tx_first_q <= 1'b0;
            ctrl_seq_q <= 1'b0;
            bulk_seq_q <= 1'b0;
            ctrl_cnt_q <= 4'h0;
            bulk_cnt_q <= 4'h0;
            hs_stall_q <= 1'b0;
            hs_ack_q <= 1'b0;
            hs_nak_q <= 1'b0;
        end else begin
            reply_valid <= 1'b0;
            stall_clear <= 1'b0;
            if (host_ack)
                in_pend_q <= 1'b0;
            if (tok_valid) begin
                cur_ours_q <= tok_ours;
                cur_kind_q <= tok_kind;
                cur_ep_q <= tok_ep;
                accept_q <= tok_accept;
                cnt_q <= 4'h0;
                in_pend_q <= 1'b0;
                if (tok_ours && tok_kind == `TOK_SETUP && tok_ep == 2'h0)
                    stall_clear <= 1'b1; // [R24]
                if (tok_ours && tok_kind == `TOK_IN) begin
                    reply_valid <= 1'b1;
                    reply_code <= `REPLY_NAK;
                    case (tok_ep)
                        2'h0: begin
                            if (ctrl_in_stall_req)
                                reply_code <= `REPLY_STALL;
                            else if (ctrl_tx_ready && !flags_q[F_CTX])
                                reply_code <= `REPLY_DATA; // [R23]
                            hs_stall_q <= ctrl_in_stall_req; // [R18]
                            hs_ack_q <= 1'b0;
                            hs_nak_q <= !ctrl_in_stall_req &&
                                !(ctrl_tx_ready && !flags_q[F_CTX]);
                            in_pend_q <= !ctrl_in_stall_req &&
                                ctrl_tx_ready && !flags_q[F_CTX];
                        end
                        2'h1: begin
                            if (intr_stall_req)
                                reply_code <= `REPLY_STALL;
                            else if (intr_tx_ready && !flags_q[F_ITX])
                                reply_code <= `REPLY_DATA; // [R10]
                            in_pend_q <= !intr_stall_req && intr_tx_ready &&
                                !flags_q[F_ITX];
                        end
                        default: begin
                            if (bulk_stall_req)
                                reply_code <= `REPLY_STALL;
                            else if (bulk_tx_ready && !flags_q[F_BTX])
                                reply_code <= `REPLY_DATA; // [R10]
                            in_pend_q <= !bulk_stall_req && bulk_tx_ready &&
                                !flags_q[F_BTX];
                        end
                    endcase
                end
            end else if (rx_byte_valid && cnt_q != 4'h8) begin
                cnt_q <= cnt_q + 1'b1;
            end
            // Corrupt packets get no handshake, as the host expects
            if (rx_end && rx_good && cur_ours_q && cur_kind_q != `TOK_IN) begin
                reply_valid <= 1'b1;
                if (cur_ep_q == 2'h0 && cur_kind_q != `TOK_SETUP &&
                    ctrl_out_stall_req)
                    reply_code <= `REPLY_STALL;
                else if (cur_ep_q != 2'h0 && bulk_stall_req)
                    reply_code <= `REPLY_STALL;
                else if (accept_q)
                    reply_code <= `REPLY_ACK; // [R12]
                else
                    reply_code <= `REPLY_NAK; // [R10]
                if (cur_ep_q == 2'h0) begin // [R18]
                    hs_stall_q <= cur_kind_q != `TOK_SETUP &&
                        ctrl_out_stall_req;
                    hs_ack_q <= (cur_kind_q == `TOK_SETUP ||
                        !ctrl_out_stall_req) && accept_q;
                    hs_nak_q <= cur_kind_q != `TOK_SETUP &&
                        !ctrl_out_stall_req && !accept_q;
                end
                if (accept_q && cur_ep_q == 2'h0) begin
                    setup_q <= cur_kind_q == `TOK_SETUP; // [R13]
                    tx_first_q <= flags_q[F_CTX]; // [R14]
                    ctrl_seq_q <= rx_pid_data1; // [R16]
                    ctrl_cnt_q <= cnt_q; // [R17]
                end else if (accept_q) begin
                    bulk_seq_q <= rx_pid_data1; // [R16]
                    bulk_cnt_q <= cnt_q; // [R17]
                end
            end
        end
    end

    // Receive buffer fill; bytes past the eighth are dropped
    always @(posedge clock) begin
        if (rx_byte_valid && !tok_valid && cur_ours_q && accept_q &&
            cur_kind_q != `TOK_IN && cnt_q != 4'h8)
            rx_buf[{cur_ep_q[1], cnt_q[2:0]}] <= rx_byte;
    end

    // CPU writes to endpoint transmit buffers
    always @(posedge clock) begin
        if (sfr_wr && sfr_addr == `OFS_CTRL_EP_PORT)
            tx_buf[ep_base(2'h0) + {2'h0, ptr_q}] <= sfr_wdata; // [R20]
        else if (sfr_wr && sfr_addr == `OFS_INTR_EP_PORT)
            tx_buf[ep_base(2'h1) + {2'h0, ptr_q}] <= sfr_wdata; // [R21]
        else if (sfr_wr && sfr_addr == `OFS_BULK_EP_PORT)
            tx_buf[ep_base(2'h2) + {2'h0, ptr_q}] <= sfr_wdata; // [R20]
    end

    // Registers, read data and interrupt
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            en_q <= `RST_BYTE;
            flags_q <= `RST_BYTE;
            ien_main_q <= `RST_BYTE;
            ien_extra_q <= `RST_BYTE;
            device_address <= 7'h00;
            ptr_q <= 3'h0;
            sfr_rdata <= 8'h00;
            tx_rd_data <= 8'h00;
            suspend <= 1'b0;
            cpu_wake <= 1'b0;
            irq <= 1'b0;
        end else begin
            flags_q <= flags_d;
            if (sfr_wr && sfr_addr == `OFS_SUSPEND_IRQ_EN)
                en_q <= sfr_wdata;
            if (sfr_wr && sfr_addr == `OFS_DEVICE_ADDRESS)
                device_address <= sfr_wdata[6:0]; // [R3]
            if (sfr_wr && sfr_addr == `OFS_IRQ_EN_MAIN)
                ien_main_q <= sfr_wdata;
            if (sfr_wr && sfr_addr == `OFS_IRQ_EN_EXTRA)
                ien_extra_q <= sfr_wdata;
            if (sfr_wr && sfr_addr == `OFS_BUF_POINTER)
                ptr_q <= sfr_wdata[2:0];
            else if ((sfr_wr || sfr_rd) && port_hit(sfr_addr))
                ptr_q <= ptr_q + 1'b1; // [R19]
            // Suspend follows its enable bit and arms resume detection; software owns its timing
            suspend <= en_q[`BIT_SUSPEND]; // [R1]
            if (tx_rd_req)
                tx_rd_data <= tx_buf[ep_base(cur_ep_q) + {2'h0, tx_rd_idx}];
            // Wake the CPU first; the resume request waits for stop to end
            cpu_wake <= flags_q[`BIT_RESUME] && stop_mode; // [R4]
            irq <= ien_main_q[`BIT_ALL_IRQ_EN] &&
                ien_extra_q[`BIT_USB_GROUP_EN] && // [R22]
                ((flags_q[`BIT_RESUME] && !stop_mode) ||
                |(flags_q[6:0] & en_q[6:0])); // [R2] [R25]
            sfr_rdata <= 8'h00;
            if (sfr_rd) begin
                case (sfr_addr)
                    `OFS_SUSPEND_IRQ_EN: sfr_rdata <= en_q;
                    `OFS_DEVICE_ADDRESS: sfr_rdata <= {1'b0, device_address};
                    `OFS_EVENT_FLAGS: sfr_rdata <= flags_q;
                    `OFS_CTRL_RX_STATUS: sfr_rdata <= {setup_q, tx_first_q,
                        idle_q, ctrl_seq_q, ctrl_cnt_q};
                    `OFS_HS_EP_STATUS: sfr_rdata <= {hs_stall_q, hs_ack_q,
                        hs_nak_q, bulk_seq_q, bulk_cnt_q};
                    `OFS_BUF_POINTER: sfr_rdata <= {5'h00, ptr_q};
                    `OFS_CTRL_EP_PORT: sfr_rdata <= rx_buf[{1'b0, ptr_q}];
                    `OFS_INTR_EP_PORT:
                        sfr_rdata <= tx_buf[ep_base(2'h1) + {2'h0, ptr_q}];
                    `OFS_BULK_EP_PORT: sfr_rdata <= rx_buf[{1'b1, ptr_q}];
                    `OFS_IRQ_EN_MAIN: sfr_rdata <= ien_main_q;
                    `OFS_IRQ_EN_EXTRA: sfr_rdata <= ien_extra_q;
                    default: sfr_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule

/* test/usb_status_buffer_chk.sv */
// Assertion checker for the USB status and buffer block
`timescale 1ns/1ps
`include "usb_status_defs.vh"
module usb_status_buffer_chk (
    input wire clock, nrst, sfr_wr, stop_mode, ctrl_tx_ready,
    input wire ctrl_in_stall_req, tok_valid, rx_end, rx_good,
    input wire reply_valid, stall_clear, suspend, cpu_wake, irq,
    input wire [7:0] sfr_addr, sfr_wdata,
    input wire [1:0] tok_kind, tok_ep, reply_code,
    input wire [6:0] tok_addr, device_address
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    reg main_q;
    reg extra_q;
    reg setup_q;
    wire gate = main_q & extra_q;
    wire ours = tok_valid && tok_addr == device_address && tok_ep == 2'h0;
    // Shadow both enable bits, the bodies being out of sight
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            main_q <= 1'b0;
            extra_q <= 1'b0;
            setup_q <= 1'b0;
        end else begin
            if (sfr_wr && sfr_addr == `OFS_IRQ_EN_MAIN)
                main_q <= sfr_wdata[7];
            if (sfr_wr && sfr_addr == `OFS_IRQ_EN_EXTRA)
                extra_q <= sfr_wdata[4];
            if (tok_valid)
                setup_q <= ours && tok_kind == `TOK_SETUP;
        end
    end
    addr_load_a: assert property (
        sfr_wr && sfr_addr == `OFS_DEVICE_ADDRESS |=>
        device_address == $past(sfr_wdata[6:0])) else $error("address");
    in_nak_a: assert property (
        ours && tok_kind == `TOK_IN && !ctrl_tx_ready && !ctrl_in_stall_req
        |=> reply_valid && reply_code == `REPLY_NAK) else $error("in nak");
    reply_cause_a: assert property (
        reply_valid |-> $past(tok_valid) || $past(rx_end))
        else $error("reply without cause");
    setup_clr_a: assert property (
        ours && tok_kind == `TOK_SETUP |-> ##[1:2] stall_clear)
        else $error("stall clear");
    setup_ack_a: assert property (
        setup_q && rx_end && rx_good |=>
        reply_valid && reply_code == `REPLY_ACK) else $error("setup ack");
    irq_gate_a: assert property (
        irq |-> $past(gate)) else $error("irq gating");
    irq_hold_a: assert property (
        irq && !sfr_wr && !$past(sfr_wr) && !stop_mode |=> irq)
        else $error("irq dropped");
    wake_stop_a: assert property (
        cpu_wake |-> $past(stop_mode)) else $error("wake outside stop");
    susp_follow_a: assert property (
        sfr_wr && sfr_addr == `OFS_SUSPEND_IRQ_EN |=> ##1
        suspend == $past(sfr_wdata[7], 2)) else $error("suspend");
    cover property (reply_valid && reply_code == `REPLY_ACK);
    cover property (reply_valid && reply_code == `REPLY_STALL);
    cover property (irq);
    cover property (cpu_wake);
endmodule
bind usb_status_buffer usb_status_buffer_chk i_usb_status_buffer_chk (.*);

/* test/usb_host_model.sv */
// Behavioural full-speed host seen through the packet engine
`timescale 1ns/1ps
`include "usb_status_defs.vh"
module usb_host_model (
    input wire clock, reply_valid,
    input wire [1:0] reply_code,
    input wire [7:0] tx_rd_data,
    output reg dp_in = 1'b1, dm_in = 1'b0, tok_valid = 1'b0,
    output reg [1:0] tok_kind = 2'h0, tok_ep = 2'h0,
    output reg [6:0] tok_addr = 7'h00,
    output reg rx_byte_valid = 1'b0, rx_end = 1'b0, rx_good = 1'b0,
    output reg [7:0] rx_byte = 8'h00,
    output reg rx_pid_data1 = 1'b0, host_ack = 1'b0, tx_rd_req = 1'b0,
    output reg [2:0] tx_rd_idx = 3'h0
);
    reg got = 1'b0;
    reg [1:0] code = 2'h0;
    reg [7:0] tx_seen = 8'h00;
    task step;
        begin
            @(posedge clock);
            #1;
        end
    endtask
    // Hold a line state, then fall back to idle J
    task line(input p, input m, input integer n);
        begin
            step;
            dp_in = p;
            dm_in = m;
            repeat (n) step;
            dp_in = 1'b1;
            dm_in = 1'b0;
        end
    endtask
    task wait_reply;
        integer i;
        begin
            got = 1'b0;
            for (i = 0; i < 6 && !got; i = i + 1) begin
                if (reply_valid === 1'b1) begin
                    got = 1'b1;
                    code = reply_code;
                end else
                    step;
            end
        end
    endtask
    task token(input [1:0] k, input [6:0] a);
        begin
            step;
            tok_valid = 1'b1;
            tok_kind = k;
            tok_addr = a;
            step;
            tok_valid = 1'b0;
        end
    endtask
    task packet(input [1:0] k, input [6:0] a, input integer n, input d1);
        integer i;
        begin
            token(k, a);
            for (i = 0; i < n; i = i + 1) begin
                rx_byte_valid = 1'b1;
                rx_byte = 8'hA0 + i[7:0];
                step;
            end
            rx_byte_valid = 1'b0;
            // Released data must not linger as a plausible byte
            rx_byte = ~rx_byte;
            rx_end = 1'b1;
            rx_good = 1'b1;
            rx_pid_data1 = d1;
            step;
            rx_end = 1'b0;
            rx_good = 1'b0;
            wait_reply;
        end
    endtask
    task in_xfer(input [6:0] a);
        begin
            token(`TOK_IN, a);
            wait_reply;
            if (got && code == `REPLY_DATA) begin
                step;
                tx_rd_req = 1'b1;
                step;
                tx_rd_req = 1'b0;
                tx_seen = tx_rd_data;
                host_ack = 1'b1;
                step;
                host_ack = 1'b0;
            end
        end
    endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the USB status and buffer block
`timescale 1ns/1ps
`include "usb_status_defs.vh"
`define H i_usb_host_model
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    err_total++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
    reg clock = 1'b0;
    reg nrst = 1'b0;
    reg sfr_wr = 1'b0;
    reg sfr_rd = 1'b0;
    reg [7:0] sfr_addr = 8'h00;
    reg [7:0] sfr_wdata = 8'h00;
    reg stop_mode = 1'b0;
    reg ctrl_tx_ready = 1'b0;
    reg ctrl_rx_ready = 1'b0;
    reg in_stall = 1'b0;
    reg out_stall = 1'b0;
    reg intr_tx_ready = 1'b0;
    reg bulk_tx_ready = 1'b0;
    reg bulk_rx_ready = 1'b0;
    reg intr_stall_req = 1'b0;
    reg bulk_stall_req = 1'b0;
    wire ctrl_in_stall_req = in_stall;
    wire ctrl_out_stall_req = out_stall;
    wire stall_clear;
    int err_total = 0;
    int check_count = 0;
    integer i;
    wire dp_in, dm_in, tok_valid, rx_byte_valid, rx_end, rx_good;
    wire rx_pid_data1, host_ack, tx_rd_req, reply_valid, suspend;
    wire cpu_wake, irq;
    wire [1:0] tok_kind, tok_ep, reply_code;
    wire [6:0] tok_addr, device_address;
    wire [7:0] rx_byte, tx_rd_data, sfr_rdata;
    wire [2:0] tx_rd_idx;
    // Short line timings keep the run brief
    usb_status_buffer #(.RESET_CYC(20), .EOP_CYC(4), .IDLE_CYC(10))
    i_usb_status_buffer (.*);
    usb_host_model i_usb_host_model (.*);
    initial begin
        forever #2.5 clock = ~clock;
    end
    task pause(input integer n);
        begin
            repeat (n) @(posedge clock);
            #1;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            pause(1);
            sfr_addr = a;
            sfr_wdata = d;
            sfr_wr = 1'b1;
            pause(1);
            sfr_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            pause(1);
            sfr_addr = a;
            sfr_rd = 1'b1;
            pause(1);
            sfr_rd = 1'b0;
            `CHK($sformatf("reg %h", a), e, sfr_rdata)
        end
    endtask
    task rep(input [2:0] e);
        `CHK("reply", e, {`H.got, `H.code})
    endtask
    task irq_is(input e);
        begin
            pause(2);
            `CHK("irq", e, irq)
        end
    endtask
    task stop_test;
        begin
            $display("Checks %0d, errors %0d", check_count, err_total);
            if (err_total == 0 && check_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        pause(6);
        nrst = 1'b1;
        pause(16);
        rd(`OFS_EVENT_FLAGS, 8'h00);
        rd(`OFS_HS_EP_STATUS, 8'h00);
        rd(`OFS_CTRL_RX_STATUS, 8'h20);
        rd(8'h10, 8'h00);
        wr(`OFS_DEVICE_ADDRESS, 8'hFF);
        rd(`OFS_DEVICE_ADDRESS, 8'h7F);
        wr(`OFS_DEVICE_ADDRESS, 8'h05);
        wr(`OFS_BUF_POINTER, 8'h00);
        for (i = 0; i < 8; i = i + 1)
            wr(`OFS_INTR_EP_PORT, 8'h10 + i[7:0]);
        // Eight accesses wrap the pointer back to byte 0
        for (i = 0; i < 8; i = i + 1)
            rd(`OFS_INTR_EP_PORT, 8'h10 + i[7:0]);
        wr(`OFS_BUF_POINTER, 8'h00);
        wr(`OFS_CTRL_EP_PORT, 8'h5A);
        `H.packet(`TOK_OUT, 7'h06, 2, 1'b0);
        `CHK("foreign", 1'b0, `H.got)
        ctrl_rx_ready = 1'b1;
        `H.packet(`TOK_OUT, 7'h05, 3, 1'b1);
        rep(3'h5);
        rd(`OFS_EVENT_FLAGS, 8'h02);
        rd(`OFS_CTRL_RX_STATUS, 8'h33);
        rd(`OFS_HS_EP_STATUS, 8'h40);
        wr(`OFS_BUF_POINTER, 8'h00);
        for (i = 0; i < 3; i = i + 1)
            rd(`OFS_CTRL_EP_PORT, 8'hA0 + i[7:0]);
        `H.packet(`TOK_OUT, 7'h05, 1, 1'b0);
        rep(3'h6);
        rd(`OFS_HS_EP_STATUS, 8'h20);
        in_stall = 1'b1;
        out_stall = 1'b1;
        `H.packet(`TOK_SETUP, 7'h05, 9, 1'b0);
        rep(3'h5);
        in_stall = 1'b0;
        out_stall = 1'b0;
        rd(`OFS_CTRL_RX_STATUS, 8'hA8);
        ctrl_rx_ready = 1'b0;
        wr(`OFS_EVENT_FLAGS, 8'h00);
        rd(`OFS_EVENT_FLAGS, 8'h02);
        wr(`OFS_EVENT_FLAGS, 8'h02);
        rd(`OFS_EVENT_FLAGS, 8'h00);
        `H.packet(`TOK_OUT, 7'h05, 1, 1'b0);
        rep(3'h6);
        `H.in_xfer(7'h05);
        rep(3'h6);
        in_stall = 1'b1;
        `H.in_xfer(7'h05);
        rep(3'h7);
        rd(`OFS_HS_EP_STATUS, 8'h80);
        in_stall = 1'b0;
        ctrl_tx_ready = 1'b1;
        `H.in_xfer(7'h05);
        rep(3'h4);
        `CHK("tx byte", 8'h5A, `H.tx_seen)
        rd(`OFS_EVENT_FLAGS, 8'h01);
        `H.in_xfer(7'h05);
        rep(3'h6);
        ctrl_rx_ready = 1'b1;
        `H.packet(`TOK_OUT, 7'h05, 1, 1'b0);
        rep(3'h5);
        rd(`OFS_CTRL_RX_STATUS, 8'h61);
        `H.tok_ep = 2'h1;
        intr_stall_req = 1'b1;
        `H.in_xfer(7'h05);
        rep(3'h7);
        intr_stall_req = 1'b0;
        intr_tx_ready = 1'b1;
        `H.in_xfer(7'h05);
        rep(3'h4);
        `CHK("intr byte", 8'h10, `H.tx_seen)
        `H.tok_ep = 2'h2;
        bulk_rx_ready = 1'b1;
        `H.packet(`TOK_OUT, 7'h05, 2, 1'b1);
        rep(3'h5);
        rd(`OFS_HS_EP_STATUS, 8'h52);
        bulk_tx_ready = 1'b1;
        `H.in_xfer(7'h05);
        rep(3'h4);
        rd(`OFS_EVENT_FLAGS, 8'h1F);
        `H.tok_ep = 2'h0;
        wr(`OFS_IRQ_EN_MAIN, 8'h80);
        wr(`OFS_IRQ_EN_EXTRA, 8'h10);
        irq_is(1'b0);
        wr(`OFS_SUSPEND_IRQ_EN, 8'h02);
        irq_is(1'b1);
        wr(`OFS_IRQ_EN_EXTRA, 8'h00);
        irq_is(1'b0);
        wr(`OFS_IRQ_EN_EXTRA, 8'h10);
        wr(`OFS_EVENT_FLAGS, 8'h02);
        irq_is(1'b0);
        wr(`OFS_EVENT_FLAGS, 8'hFF);
        `H.line(1'b0, 1'b0, 25);
        pause(4);
        rd(`OFS_EVENT_FLAGS, 8'h40);
        wr(`OFS_EVENT_FLAGS, 8'hFF);
        `H.line(1'b0, 1'b0, 6);
        pause(4);
        rd(`OFS_EVENT_FLAGS, 8'h20);
        wr(`OFS_EVENT_FLAGS, 8'hFF);
        wr(`OFS_SUSPEND_IRQ_EN, 8'h80);
        pause(2);
        `CHK("suspend", 1'b1, suspend)
        stop_mode = 1'b1;
        `H.line(1'b0, 1'b1, 3);
        pause(4);
        `CHK("wake", 1'b1, cpu_wake)
        `CHK("irq in stop", 1'b0, irq)
        rd(`OFS_EVENT_FLAGS, 8'h80);
        stop_mode = 1'b0;
        irq_is(1'b1);
        wr(`OFS_SUSPEND_IRQ_EN, 8'h00);
        wr(`OFS_EVENT_FLAGS, 8'h80);
        irq_is(1'b0);
        stop_test;
    end
endmodule
